// ---- uart_ctl_pkg.sv ----
// uart_ctl_pkg: shared constants and carrier types of the serial port
// control block; assumes a 32-bit apb master on the same clock.
package uart_ctl_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_IER = 8'h04; // irq_enable_reg
    localparam logic [7:0] OFS_IIR = 8'h08; // irq_ident_reg rd, fifo wr
    localparam logic [7:0] OFS_LCR = 8'h0c; // line_control
    localparam logic [7:0] OFS_LSR = 8'h14; // line_status_reg
    localparam logic [7:0] OFS_DLL = 8'h20; // divisor_low
    localparam logic [7:0] OFS_DLH = 8'h24; // divisor_high
    localparam logic [7:0] OFS_PEC = 8'h30; // power_emu_control

    // irq_enable_reg fields
    localparam int IER_RXA = 0; // rx_available_irq_en
    localparam int IER_TXE = 1; // tx_empty_irq_en
    localparam int IER_LS = 2; // line_status_irq_en
    // fifo_control fields
    localparam int FCR_EN = 0; // fifo_enable_bit
    localparam int FCR_TRG = 6; // rx_trigger_select, two bits
    // power_emu_control fields
    localparam int PEC_FREE = 0;
    localparam int PEC_RXR = 13; // rx_reset_release
    localparam int PEC_TXR = 14; // tx_reset_release
    // line_status_reg fields
    localparam int LSR_DR = 0; // rx_ready_flag
    localparam int LSR_OE = 1;
    localparam int LSR_PE = 2; // parity_error_flag
    localparam int LSR_FE = 3; // framing_error_flag
    localparam int LSR_BI = 4; // break_flag
    localparam int LSR_TX_HOLDING_EMPTY_FLAG = 5; // tx_holding_empty_flag
    localparam int LSR_TEMT = 6;

    // reset values
    localparam logic [2:0] IER_RST = 3'h0;
    localparam logic [7:0] FCR_RST = 8'h00;
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [2:0] PEC_RST = 3'h0;

    // identification codes, bit 0 high means nothing pending
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_RXA = 4'h4;
    localparam logic [3:0] ID_TMO = 4'hc;
    localparam logic [3:0] ID_TXE = 4'h2;

    // timing: oversampling and the timeout in character times
    localparam int OVERSAMPLE = 16;
    localparam int CHAR_TIMES = 4;
    localparam int BASE_BITS = 8; // char bits for 5-bit words

    // receive path status, from the datapath on clk_sys
    typedef struct packed {
        logic [4:0] level; // characters held
        logic push; // character entered, pulse
        logic pop; // character read, pulse
        logic head_err; // head character carries an error
        logic [3:0] err; // overrun, parity, framing, break pulses
        logic busy; // word in progress
    } rx_stat_t;

    // transmit path status, from the datapath on clk_sys
    typedef struct packed {
        logic empty; // holding or fifo empty, all moved out
        logic shifter_empty; // shifter idle too
        logic last_move; // last byte moved to shifter, pulse
        logic load; // holding/fifo written, pulse
        logic busy; // word in progress
    } tx_stat_t;

    // control handed to the datapath
    typedef struct packed {
        logic tx_run; // transmitter out of reset, not halted
        logic rx_run; // receiver out of reset, not halted
        logic fifo_mode;
        logic [1:0] word_len;
        logic baud_clk; // 16x baud level
        logic baud_tick; // 16x baud enable, pulse
    } ctl_out_t;

endpackage : uart_ctl_pkg

// ---- uart_irq_dma_reset_ctrl.sv ----
// uart_irq_dma_reset_ctrl: soft resets, interrupt arbiter, dma requests,
// suspend halting and baud clock of the serial port.
// assumes apb on clk_sys and a datapath on the same clock.
`timescale 1ns/10ps
`default_nettype none

// How it works
// R1: transmitter runs only with its release set
// R2: receiver runs only with its release set
// R3: soft reset clears side state, not registers
// R4: device reset forces state and registers
// R5: software order: divisor, fifo, line, modem, release
// R6: fifo enable written alone first
// R7: one arbitrated interrupt line, unshared
// R8: disabled requests not forwarded; timeout and line errors still recorded
// R9: tx empty request, gated by its enable
// R10: rx available request, level or trigger
// R11: ready flag shows only unread characters
// R12: fifo timeout after four idle character times
// R13: timeout uses rx enable, no status flag
// R14: line request on errors, flags pollable
// R15: rx dma request at trigger or timeout
// R16: no trigger rx dma while head char erroneous
// R17: tx dma on last move or release
// R18: no dma requests outside fifo mode
// R19: dma channel enabled before the request
// R20: suspend halts after current word unless free
// R21: debug reads harmless except ident register
// R22: divisor unreset, baud clock high until set
// R23: line above rx/timeout above tx empty
// R24: ident read clears tx empty request
// R25: timeout cleared by read, push, rx release
// R26: interrupt held while enabled requests pend
module uart_irq_dma_reset_ctrl #(
    parameter int TMO_W = 10 // timeout timer width
) (
    input wire logic clk_sys,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic dbg_access,
    // emulation suspend, asynchronous pin
    input wire logic emu_suspend,
    // datapath status
    input wire uart_ctl_pkg::rx_stat_t rx_stat,
    input wire uart_ctl_pkg::tx_stat_t tx_stat,
    // outputs
    output uart_ctl_pkg::ctl_out_t ctl,
    output logic irq,
    output logic rx_dma_request,
    output logic tx_dma_request
);
    import uart_ctl_pkg::*;

    localparam int MAX_LIM = (BASE_BITS + 3) * CHAR_TIMES * OVERSAMPLE;

    // refuse a timer too narrow for the longest timeout
    if (MAX_LIM >= (1 << TMO_W)) begin : g_chk
        $error("TMO_W too small for timeout");
    end

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [2:0] irq_enable_reg; // request enables
        logic [7:0] fifo_control; // fifo_control
        logic [7:0] line_control; // line_control
        logic [2:0] pec; // free, rx release, tx release
        logic [3:0] lsr_err; // sticky oe, pe, fe, bi
        logic txe_pend; // recorded tx empty request
        logic txe_prev; // tx empty seen last cycle
        logic tmo_pend; // recorded timeout request
        logic [TMO_W-1:0] tmo_cnt; // idle ticks
        logic trg_prev; // trigger reached last cycle
        logic tx_halt;
        logic rx_halt;
        logic div_set; // divisor written since reset
        logic [15:0] bcnt; // baud divider
        logic bclk; // baud level
        logic btick;
        logic rxdma;
        logic txdma;
        logic [31:0] rdata;
        logic sus_a; // synchroniser stage one
        logic sus_b; // synchroniser stage two
    } state_t;

    state_t st;
    state_t next_st;
    logic [15:0] div; // divisor latch, deliberately without reset
    logic [15:0] next_div;

    logic setup; // apb setup phase
    logic acc; // apb access completing
    logic wr;
    logic rd;
    logic hit;
    logic fifo_mode;
    logic [4:0] trig; // trigger level in characters
    logic at_trig; // rx level at or above trigger
    logic rxa_req; // rx available condition
    logic ls_req;
    logic [TMO_W-1:0] tmo_lim;
    logic [3:0] id;
    logic [7:0] irq_ident_reg;
    logic [7:0] line_status_reg;
    logic tx_rel_rise;
    logic suspend;

    ////////////////////////////////////////////////////////////////////
    // combinational decode
    always_comb begin
        setup = psel & ~penable;
        acc = psel & penable;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        hit = (paddr == OFS_IER) || (paddr == OFS_IIR)
            || (paddr == OFS_LCR) || (paddr == OFS_LSR)
            || (paddr == OFS_DLL) || (paddr == OFS_DLH)
            || (paddr == OFS_PEC);
        fifo_mode = st.fifo_control[FCR_EN];
        // trigger encodings 1, 4, 8, 14
        case (st.fifo_control[FCR_TRG +: 2])
            2'h0: trig = 5'h01;
            2'h1: trig = 5'h04;
            2'h2: trig = 5'h08;
            default: trig = 5'h0e;
        endcase
        at_trig = rx_stat.level >= trig;
        // non-fifo: any character; fifo: trigger reached
        rxa_req = fifo_mode ? at_trig : (rx_stat.level != 5'h00); // R10
        ls_req = st.irq_enable_reg[IER_LS] & (st.lsr_err != 4'h0); // R14 R8
        // character bits 8..11 times four times sixteen
        tmo_lim = TMO_W'((BASE_BITS + 32'(st.line_control[1:0]))
            * CHAR_TIMES * OVERSAMPLE); // R12
        // arbiter: line, then rx/timeout, then tx empty
        if (ls_req) begin
            id = ID_LINE; // R23
        end else if (st.irq_enable_reg[IER_RXA] & rxa_req) begin
            id = ID_RXA; // R23 R8
        end else if (st.irq_enable_reg[IER_RXA] & st.tmo_pend) begin
            id = ID_TMO; // R13
        end else if (st.txe_pend) begin
            id = ID_TXE; // R23
        end else begin
            id = ID_NONE;
        end
        irq_ident_reg = {{2{fifo_mode}}, 2'h0, id};
        // err carries {oe, pe, fe, bi}; the register wants oe lowest
        line_status_reg = {1'b0, tx_stat.shifter_empty & tx_stat.empty,
            tx_stat.empty, st.lsr_err[0], st.lsr_err[1],
            st.lsr_err[2], st.lsr_err[3],
            rx_stat.level != 5'h00}; // R11
        tx_rel_rise = next_st.pec[2] & ~st.pec[2];
        suspend = st.sus_b & ~st.pec[PEC_FREE];
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_div = div;
        // pin synchroniser, stage one read only by stage two
        next_st.sus_a = emu_suspend;
        next_st.sus_b = st.sus_a;

        // register writes; soft releases leave these alone
        if (wr) begin // R3
            case (paddr)
                OFS_IER: next_st.irq_enable_reg = pwdata[2:0];
                OFS_IIR: next_st.fifo_control = pwdata[7:0]; // R6
                OFS_LCR: next_st.line_control = pwdata[7:0];
                OFS_DLL: begin
                    next_div[7:0] = pwdata[7:0];
                    next_st.div_set = 1'b1;
                end
                OFS_DLH: begin
                    next_div[15:8] = pwdata[7:0];
                    next_st.div_set = 1'b1;
                end
                OFS_PEC: next_st.pec = {pwdata[PEC_TXR],
                    pwdata[PEC_RXR], pwdata[PEC_FREE]}; // R5
                default: begin
                end
            endcase
        end

        // read data captured in setup, so pready can stay high
        if (setup) begin
            case (paddr)
                OFS_IER: next_st.rdata = {29'h0, st.irq_enable_reg};
                OFS_IIR: next_st.rdata = {24'h0, irq_ident_reg};
                OFS_LCR: next_st.rdata = {24'h0, st.line_control};
                OFS_LSR: next_st.rdata = {24'h0, line_status_reg};
                OFS_DLL: next_st.rdata = {24'h0, div[7:0]};
                OFS_DLH: next_st.rdata = {24'h0, div[15:8]};
                OFS_PEC: next_st.rdata = {17'h0, st.pec[2:1],
                    12'h0, st.pec[0]};
                default: next_st.rdata = 32'h0;
            endcase
        end

        // error flags: cleared by a normal lsr read, set wins
        if (rd & ~dbg_access & (paddr == OFS_LSR)) begin // R21
            next_st.lsr_err = 4'h0;
        end
        if (st.pec[1]) begin
            next_st.lsr_err = next_st.lsr_err | rx_stat.err; // R14
        end

        // tx empty request, recorded on the empty edge when enabled
        next_st.txe_prev = tx_stat.empty;
        if (tx_stat.load
            || (rd & (paddr == OFS_IIR))) begin // R24 R21
            next_st.txe_pend = 1'b0;
        end
        if (~st.irq_enable_reg[IER_TXE]) begin
            next_st.txe_pend = 1'b0; // R8
        end else if (tx_stat.empty & ~st.txe_prev) begin
            next_st.txe_pend = 1'b1; // R9
        end

        // receive timeout timer, fifo mode only
        if (~st.pec[1] | rx_stat.push | rx_stat.pop
            | ~fifo_mode | (rx_stat.level == 5'h00)) begin
            next_st.tmo_cnt = '0; // R25
            next_st.tmo_pend = 1'b0; // R25
        end else if (st.btick & ~st.rx_halt
            & (st.tmo_cnt < tmo_lim)) begin
            next_st.tmo_cnt = st.tmo_cnt + 1'b1; // R12
            if (st.tmo_cnt + 1'b1 == tmo_lim) begin
                next_st.tmo_pend = 1'b1; // R12
            end
        end

        // dma requests, one-cycle pulses
        next_st.trg_prev = at_trig;
        next_st.rxdma = fifo_mode & ( // R18
            (at_trig & ~st.trg_prev & ~rx_stat.head_err) // R15 R16
            | (next_st.tmo_pend & ~st.tmo_pend)); // R15
        next_st.txdma = fifo_mode & ( // R18
            (tx_stat.last_move & st.pec[2]) // R17
            | tx_rel_rise); // R17

        // suspend: finish current word, then stop
        if (~suspend) begin
            next_st.tx_halt = 1'b0; // R20
            next_st.rx_halt = 1'b0; // R20
        end else begin
            if (~tx_stat.busy) begin
                next_st.tx_halt = 1'b1; // R20
            end
            if (~rx_stat.busy) begin
                next_st.rx_halt = 1'b1; // R20
            end
        end

        // baud divider; constant high until a divisor is set
        next_st.btick = 1'b0;
        if (~st.div_set | (div == 16'h0000)) begin
            next_st.bcnt = 16'h0000;
            next_st.bclk = 1'b1; // R22
        end else if (st.bcnt >= div - 16'h0001) begin
            next_st.bcnt = 16'h0000;
            next_st.bclk = 1'b1;
            next_st.btick = 1'b1;
        end else begin
            next_st.bcnt = st.bcnt + 16'h0001;
            next_st.bclk = st.bcnt < (div >> 1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register: device reset forces every field
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0; // R4
            st.irq_enable_reg <= IER_RST;
            st.fifo_control <= FCR_RST;
            st.line_control <= LCR_RST;
            st.pec <= PEC_RST; // R1 R2
            st.bclk <= 1'b1; // R22
            st.txe_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // divisor latch survives device reset on purpose
    always_ff @(posedge clk_sys) begin
        div <= next_div; // R22
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        pready = 1'b1; // zero wait states
        pslverr = psel & penable & ~hit;
        prdata = st.rdata;
        ctl.tx_run = st.pec[2] & ~st.tx_halt; // R1 R20
        ctl.rx_run = st.pec[1] & ~st.rx_halt; // R2 R20
        ctl.fifo_mode = st.fifo_control[FCR_EN];
        ctl.word_len = st.line_control[1:0];
        ctl.baud_clk = st.bclk; // R22
        ctl.baud_tick = st.btick;
        // single line, held while any enabled request pends
        irq = (st.irq_enable_reg[IER_LS] & (st.lsr_err != 4'h0))
            | (st.irq_enable_reg[IER_RXA] & ((st.fifo_control[FCR_EN]
            ? (rx_stat.level >= trig) : (rx_stat.level != 5'h00))
            | st.tmo_pend))
            | st.txe_pend; // R7 R26
        rx_dma_request = st.rxdma; // R19
        tx_dma_request = st.txdma;
    end

endmodule : uart_irq_dma_reset_ctrl

`default_nettype wire

// ---- uart_ctl_sva.sv ----
// checker for the serial port control block, watching its ports only
// assumes it is bound onto the block's top module
`timescale 1ns/10ps
`default_nettype none
module uart_ctl_sva #(
    parameter int TMO_W = 10 // timeout timer width, unused here
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic dbg_access,
    input wire logic emu_suspend,
    input wire uart_ctl_pkg::rx_stat_t rx_stat,
    input wire uart_ctl_pkg::tx_stat_t tx_stat,
    input wire uart_ctl_pkg::ctl_out_t ctl,
    input wire logic irq,
    input wire logic rx_dma_request,
    input wire logic tx_dma_request
);
    import uart_ctl_pkg::*;
    //////////////////////////////////////
    // divisor survives reset, so this flag is never cleared by nrst
    logic div_seen = 1'b0;
    // set on the first divisor write
    always @(posedge clk_sys) begin
        if (psel && penable && pwrite && paddr inside {OFS_DLL, OFS_DLH})
            div_seen <= 1'b1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // completed apb write to one address
    sequence s_wr(a);
        psel && penable && pwrite && paddr == a;
    endsequence
    AST_TX_HOLD: assert property (
        s_wr(OFS_PEC) ##0 !pwdata[PEC_TXR] |=> !ctl.tx_run)
        else $error("transmitter runs with release low");
    AST_RX_HOLD: assert property (
        s_wr(OFS_PEC) ##0 !pwdata[PEC_RXR] |=> !ctl.rx_run)
        else $error("receiver runs with release low");
    AST_IER_OFF: assert property (
        s_wr(OFS_IER) ##0 pwdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt with all enables off");
    AST_NO_DMA: assert property (
        !ctl.fifo_mode && !$past(ctl.fifo_mode)
        |-> !rx_dma_request && !tx_dma_request)
        else $error("dma request outside fifo mode");
    AST_TX_DMA: assert property (
        ctl.fifo_mode && ctl.tx_run && tx_stat.last_move |=> tx_dma_request)
        else $error("no tx dma after last move");
    AST_HEAD_ERR: assert property (
        ctl.fifo_mode && rx_stat.head_err && rx_stat.push
        |=> !rx_dma_request)
        else $error("rx dma with erroneous head");
    AST_BAUD_IDLE: assert property (
        !div_seen |-> ctl.baud_clk)
        else $error("baud clock moves before divisor set");
    AST_READY_FLAG: assert property (
        psel && penable && !pwrite && paddr == OFS_LSR
        |-> prdata[LSR_DR] == ($past(rx_stat.level) != 5'h0))
        else $error("ready flag differs from fifo level");
endmodule : uart_ctl_sva
`default_nettype wire

// ---- uart_dma_model.sv ----
// dma controller model: counts requests seen on enabled channels
// assumes one-cycle request pulses on clk_sys
`timescale 1ns/10ps
`default_nettype none
module uart_dma_model (
    input wire logic clk_sys,
    input wire logic ch_en,
    input wire logic rx_dma_request,
    input wire logic tx_dma_request,
    output var int rx_cnt,
    output var int tx_cnt
);
    initial begin
        rx_cnt = 0;
        tx_cnt = 0;
    end
    // a request met with the channel off is lost, no retry
    always @(posedge clk_sys) begin
        if (ch_en && rx_dma_request === 1'b1)
            rx_cnt <= rx_cnt + 1;
        if (ch_en && tx_dma_request === 1'b1)
            tx_cnt <= tx_cnt + 1;
    end
endmodule : uart_dma_model
`default_nettype wire

// ---- testbench.sv ----
// testbench: apb register rows, then interrupt, dma and reset cases
// assumes the control block, its checker and the dma model
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import uart_ctl_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d; // write data, or expected read data
        logic err;
    } row_t;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic dbg_access = 1'b0, emu_suspend = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, irq, rx_dma_request, tx_dma_request, e;
    rx_stat_t rx_stat = '0;
    tx_stat_t tx_stat = '0;
    ctl_out_t ctl;
    int rx_cnt, tx_cnt, bad_count = 0, checked = 0;
    logic ch_en = 1'b1; // dma channel enable of the partner
    row_t rows [9] = '{'{1, OFS_IER, 0, 0}, '{0, OFS_IER, 0, 0},
        '{1, OFS_IER, 7, 0}, '{0, OFS_IER, 7, 0}, '{1, OFS_LCR, 3, 0},
        '{0, OFS_LCR, 3, 0}, '{0, OFS_DLL, 1, 0},
        '{0, OFS_IIR, 32'hc1, 0}, '{0, 8'h3c, 0, 1}};
    always #10 clk_sys = ~clk_sys;
    uart_irq_dma_reset_ctrl u_uart_irq_dma_reset_ctrl (.clk_sys, .nrst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .dbg_access, .emu_suspend, .rx_stat, .tx_stat, .ctl,
        .irq, .rx_dma_request, .tx_dma_request);
    uart_dma_model u_uart_dma_model (.clk_sys, .ch_en,
        .rx_dma_request, .tx_dma_request, .rx_cnt, .tx_cnt);
    //////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // only the watchdog ends a wait that never sees ready
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] x,
            input logic [31:0] g);
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // receive side event: new level with push or pop pulses
    task automatic rx_evt(input logic [4:0] lv, input logic ps,
            input logic pp);
        rx_stat.level <= lv;
        rx_stat.push <= ps;
        rx_stat.pop <= pp;
        tick(1);
        // every event input is a one-cycle pulse
        rx_stat.push <= 1'b0;
        rx_stat.pop <= 1'b0;
        rx_stat.err <= 4'h0;
        tx_stat.last_move <= 1'b0;
        tick(2);
    endtask : rx_evt
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    //////////////////////////////////////
    // watchdog: the whole run needs about 870 cycles
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
    initial begin
        tick(16);
        chk("irq", 0, irq);
        chk("run", 0, {ctl.tx_run, ctl.rx_run});
        chk("baud_clk", 1, ctl.baud_clk);
        nrst <= 1'b1;
        apb(1, OFS_DLL, 1);
        apb(1, OFS_DLH, 0);
        apb(1, OFS_IIR, 1);
        apb(1, OFS_IIR, 1);
        apb(1, OFS_LCR, 3);
        apb(1, OFS_PEC, 32'h6000);
        tick(2);
        chk("run", 3, {ctl.tx_run, ctl.rx_run});
        chk("tx_cnt", 1, tx_cnt);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                chk("rdata", rows[i].d, r);
            chk("pslverr", rows[i].err, e);
        end
        $display("register rows done");
        // line error, data, tx empty and last move together
        tx_stat.empty <= 1'b1;
        rx_stat.err <= 4'h4;
        tx_stat.last_move <= 1'b1;
        rx_evt(1, 1, 0);
        tick(1);
        chk("rx_cnt", 1, rx_cnt);
        chk("tx_cnt", 2, tx_cnt);
        chk("irq", 1, irq);
        dbg_access <= 1'b1;
        apb(0, OFS_LSR, 0);
        dbg_access <= 1'b0;
        chk("lsr_pe", 1, r[LSR_PE]);
        apb(0, OFS_IIR, 0);
        chk("iir", 32'hc6, r);
        apb(0, OFS_LSR, 0);
        apb(0, OFS_IIR, 0);
        chk("iir", 32'hc4, r);
        // ident reads above cleared tx empty; make a fresh empty edge
        tx_stat.empty <= 1'b0;
        rx_evt(0, 0, 1);
        tx_stat.empty <= 1'b1;
        apb(0, OFS_IIR, 0);
        chk("iir", 32'hc2, r);
        apb(0, OFS_IIR, 0);
        chk("iir", 32'hc1, r);
        chk("irq", 0, irq);
        $display("interrupt order done");
        // erroneous head, then timeout below the trigger of 4
        rx_stat.head_err <= 1'b1;
        rx_evt(1, 1, 0);
        chk("rx_cnt", 1, rx_cnt);
        rx_stat.head_err <= 1'b0;
        apb(1, OFS_IIR, 32'h41);
        rx_evt(1, 1, 0);
        apb(0, OFS_LSR, 0);
        chk("lsr_dr", 1, r[LSR_DR]);
        tick((BASE_BITS + 3) * CHAR_TIMES * OVERSAMPLE);
        apb(0, OFS_IIR, 0);
        chk("iir", 32'hcc, r);
        chk("rx_cnt", 2, rx_cnt);
        apb(1, OFS_IER, 6);
        tick(1);
        chk("irq", 0, irq);
        apb(1, OFS_IER, 7);
        rx_evt(1, 0, 1);
        apb(0, OFS_IIR, 0);
        chk("iir", 32'hc1, r);
        $display("timeout done");
        // a release edge met with the channel off is lost
        ch_en <= 1'b0;
        apb(1, OFS_PEC, 0);
        apb(1, OFS_PEC, 32'h6000);
        tick(2);
        ch_en <= 1'b1;
        chk("tx_cnt", 2, tx_cnt);
        apb(1, OFS_IIR, 0);
        tx_stat.last_move <= 1'b1;
        tick(1);
        tx_stat.last_move <= 1'b0;
        tick(2);
        chk("tx_cnt", 2, tx_cnt);
        apb(1, OFS_PEC, 0);
        tick(1);
        chk("run", 0, {ctl.tx_run, ctl.rx_run});
        apb(0, OFS_IER, 0);
        chk("ier", 7, r);
        apb(1, OFS_PEC, 32'h6000);
        emu_suspend <= 1'b1;
        tick(8);
        chk("tx_run", 0, ctl.tx_run);
        emu_suspend <= 1'b0;
        tick(8);
        chk("tx_run", 1, ctl.tx_run);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        apb(0, OFS_IER, 0);
        chk("ier", 0, r);
        chk("run", 0, {ctl.tx_run, ctl.rx_run});
        $display("suspend and reset done");
        summarize();
    end
endmodule : testbench
bind uart_irq_dma_reset_ctrl uart_ctl_sva #(.TMO_W(TMO_W)) u_sva (.*);
`default_nettype wire
